//--- design/mpfs_pkg.sv
/*
  Constants, tables and carrier types for the pin function select block.
  Assumes a single 125 MHz clock and a classic Wishbone register port.
*/
package mpfs_pkg;

  // --------------------
  // sizes and timing
  // --------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int NUM_LINES = 20;
  localparam int BREAK_MS = 6000;          // serial break length
  localparam int BLINK_MS = 250;           // association blink half period
  localparam int CLK32_HZ = 32768;         // low speed clock output
  localparam int CMD_BAUD = 9600;          // uart rate in command mode
  localparam int BREAK_CYCLES_DEF = (CLK_HZ / 1000) * BREAK_MS;
  localparam int BLINK_CYCLES_DEF = (CLK_HZ / 1000) * BLINK_MS;
  localparam int CLK32_HALF = CLK_HZ / (2 * CLK32_HZ);
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // --------------------
  // function codes
  // --------------------
  localparam logic [2:0] CODE_DISABLED = 3'h0;
  localparam logic [2:0] CODE_SPECIAL_A = 3'h1;
  localparam logic [2:0] CODE_SPECIAL_B = 3'h2;
  localparam logic [2:0] CODE_INPUT = 3'h3;
  localparam logic [2:0] CODE_OUT_LOW = 3'h4;
  localparam logic [2:0] CODE_OUT_HIGH = 3'h5;
  localparam logic [2:0] CODE_SPECIAL_C = 3'h6;
  localparam logic [2:0] CODE_SPECIAL_D = 3'h7;

  // --------------------
  // line numbers of the special lines
  // --------------------
  localparam int LINE_ASSOC = 5;
  localparam int LINE_RTS = 6;
  localparam int LINE_CTS = 7;
  localparam int LINE_SLEEP_REQ = 8;
  localparam int LINE_AWAKE = 9;
  localparam int LINE_FIRST_PWM_OUT = 10;
  localparam int LINE_SECOND_PWM_OUT = 11;
  localparam int LINE_12 = 12;
  localparam int LINE_SER_OUT = 13;
  localparam int LINE_SER_IN = 14;
  localparam int LINE_SPI_ATTENTION_OUT = 19;

  // legal code bitmap per line, line 19 first
  localparam logic [19:0][7:0] LINE_LEGAL = {
    8'h76, 8'h39, 8'h39, 8'h39, 8'h39, 8'h03, 8'h03, 8'h79, 8'h3F, 8'h3F,
    8'h3B, 8'h39, 8'hFB, 8'h3B, 8'h3B, 8'h39, 8'h39, 8'h39, 8'h39, 8'h39};
  // reset code per line, line 19 first
  localparam logic [19:0][2:0] LINE_RESET = {
    3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h1,
    3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  // line served by each pull mask bit, bit 19 first
  localparam logic [19:0][4:0] PULL_LINE = {
    5'h13, 5'h12, 5'h11, 5'h10, 5'h0F, 5'h0D, 5'h07, 5'h0B, 5'h0A, 5'h0C,
    5'h09, 5'h05, 5'h0E, 5'h08, 5'h06, 5'h00, 5'h01, 5'h02, 5'h03, 5'h04};

  // --------------------
  // register map and reset values
  // --------------------
  localparam logic [7:0] REG_FUNC_BASE = 8'h00;
  localparam logic [7:0] REG_PULL_EN = 8'h50;
  localparam logic [7:0] REG_PULL_DIR = 8'h54;
  localparam logic [7:0] REG_DUTY0 = 8'h58;
  localparam logic [7:0] REG_DUTY1 = 8'h5C;
  localparam logic [7:0] REG_STATUS = 8'h60;
  localparam logic [7:0] REG_PAD_IN = 8'h64;
  localparam logic [19:0] PULL_EN_RESET = 20'hFFFFF;
  localparam logic [19:0] PULL_DIR_RESET = 20'hFFFFF;
  localparam logic [9:0] DUTY_RESET = 10'h000;
  localparam int STAT_CMD_BIT = 0;
  localparam int STAT_REJ_BIT = 1;

  // --------------------
  // carriers
  // --------------------
  typedef struct packed {
    logic joined;             // network joined
    logic rx_buf_full;        // uart receive buffer above threshold
    logic tx_active;          // uart/radio transmit in progress
    logic awake;              // device awake
    logic rx_activity;        // receive activity
    logic uart_txd;           // serial transmit data
    logic spi_attention;      // spi attention level
    logic uart_data_present;  // uart data waiting
    logic [9:0] rssi_duty;    // rssi derived duty
  } mpfs_core_in_t;

  typedef struct packed {
    logic rts_host_ready;     // host allows sending
    logic sleep_request;      // pin sleep request level
    logic uart_rxd;           // serial receive data
    logic cmd_mode;           // command mode at CMD_BAUD
    logic ok_send;            // pulse: send the OK response
  } mpfs_core_out_t;

  typedef struct packed {
    logic [19:0] out;
    logic [19:0] oe_n;
    logic [19:0] pull_en;
    logic [19:0] pull_up;
  } mpfs_pad_t;

endpackage : mpfs_pkg

//--- design/mpfs_pin_select.sv
/*
  Pin function select: line codes, pull masks, PWM, clock, command entry.
  Assumes a Wishbone master on ref_clk and pads that obey out/oe_n/pulls.
*/
// Behaviour
// RL1 - association line: 0 off, 1 blink while joined, 3-5 digital; 2 refused
// RL2 - on every line that accepts them, 0 disables, 3 inputs, 4 drives low, 5 drives high
// RL3 - rts line: 1 rts flow control, 3-5 digital, 0 off by default
// RL4 - cts line: 1 cts default; 6 tx enable low on transmit, 7 high
// RL5 - sleep request line always controls pin sleep; codes 0, 3-5
// RL6 - first pwm line: 1 rssi pwm default, 2 duty pwm, 3-5 digital
// RL7 - second pwm line: 2 duty pwm, 3-5 digital, 0 default
// RL8 - second pwm line code 1 outputs a 32.768 kHz clock; the code divides 125 MHz by 3814, about 32.774 kHz
// RL9 - line 12: codes 0, 3-6; 6 is receive activity led; default 0
// RL10 - serial out line: 0 off, 1 uart transmit data, default 1
// RL11 - enabled serial input: 6 s break or low at reset enters command mode
// RL12 - command mode entry that way requests an OK on the uart output
// RL13 - spi attention line: 1 attention, 4/5 digital, 6 uart data present
// RL14 - pull direction bit 1 pulls up, 0 pulls down, resets 0xFFFFF
// RL15 - pull enable bit 1 enables the line pull, 0 leaves none
// RL16 - pulls act only on lines that are inputs or disabled
// RL17 - pull mask bits map to lines by a fixed table; enable resets 0xFFFFF
// RL18 - each pwm has a duty 0 to 0x3FF, default 0, used in pwm mode
// RL19 - pwm output is high for duty/1024 of each period
// RL20 - an unsupported code is refused and the old setting kept
`timescale 1ns/1ns
`default_nettype none

module mpfs_pin_select #(
  parameter int BREAK_CYCLES = mpfs_pkg::BREAK_CYCLES_DEF,
  parameter int BLINK_CYCLES = mpfs_pkg::BLINK_CYCLES_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device core side
  input wire mpfs_pkg::mpfs_core_in_t core_in,
  output mpfs_pkg::mpfs_core_out_t core_out,
  // pads
  input wire logic [19:0] pad_in,
  output mpfs_pkg::mpfs_pad_t pad
);
  import mpfs_pkg::*;

  // registers, decode and per line drive
  logic [19:0][2:0] line_func;
  logic [19:0] pull_enable_mask, pull_direction_mask, pad_meta, pad_sync;
  logic [19:0] sp_en, sp_val, passive, next_out, next_oe_n;
  logic [19:0] next_pull_en, next_pull_up;
  logic [9:0] first_pwm_duty, second_pwm_duty, pwm_cnt, first_pwm_out_duty_sel;
  logic cmd_mode, reject_flag, enter_cmd, blink_phase, clk32;
  logic wb_hit, wb_wr, is_func, code_ok, break_hit, din_enabled;
  logic [31:0] old_val, wr_val;
  logic [1:0] strap_cnt;
  logic [29:0] break_cnt;
  logic [24:0] blink_cnt;
  logic [10:0] clk32_cnt;
  logic [7:0] adr_word;
  logic [4:0] func_line;

  // merge write data into an old word under the byte enables
  function automatic logic [31:0] mpfs_byte_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_w & ~m) | (new_w & m);
  endfunction : mpfs_byte_merge

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // one wait state: ack is raised the cycle after the request is seen
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_hit & wb_we_i;
  assign adr_word = {wb_adr_i[7:2], 2'h0};
  assign is_func = adr_word < REG_PULL_EN;
  assign func_line = wb_adr_i[6:2];
  assign din_enabled = line_func[LINE_SER_IN] == CODE_SPECIAL_A;

  // current value of the addressed register, also the read data
  always_comb begin
    old_val = 32'h0;
    if (is_func) begin
      old_val = {29'h0, line_func[func_line]};
    end else begin
      unique case (adr_word)
        REG_PULL_EN: old_val = {12'h0, pull_enable_mask};
        REG_PULL_DIR: old_val = {12'h0, pull_direction_mask};
        REG_DUTY0: old_val = {22'h0, first_pwm_duty};
        REG_DUTY1: old_val = {22'h0, second_pwm_duty};
        REG_STATUS: old_val = {30'h0, reject_flag, cmd_mode};
        REG_PAD_IN: old_val = {12'h0, pad_sync};
        default: old_val = 32'h0;  // unmapped reads as zero
      endcase
    end
  end

  // a code is taken only if the line lists it as legal
  assign wr_val = mpfs_byte_merge(old_val, wb_dat_i, wb_sel_i);
  assign code_ok = (wr_val[31:3] == 29'h0) &&
                   LINE_LEGAL[func_line][wr_val[2:0]];  // see RL20

  // bus answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? old_val : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // function codes; reset values carry each line's default
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_func <= LINE_RESET;  // see RL1 see RL3 see RL4 see RL10
    end else if (wb_wr && is_func && code_ok) begin
      line_func[func_line] <= wr_val[2:0];  // see RL20
    end
  end

  // pull masks, reset to pull up every line that is disabled or an input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_enable_mask <= PULL_EN_RESET;  // see RL17
      pull_direction_mask <= PULL_DIR_RESET;  // see RL14
    end else if (wb_wr && adr_word == REG_PULL_EN) begin
      pull_enable_mask <= wr_val[19:0];
    end else if (wb_wr && adr_word == REG_PULL_DIR) begin
      pull_direction_mask <= wr_val[19:0];
    end
  end

  // pwm duties, ten bits so the range stops at 0x3FF
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_pwm_duty <= DUTY_RESET;  // see RL18
      second_pwm_duty <= DUTY_RESET;
    end else if (wb_wr && adr_word == REG_DUTY0) begin
      first_pwm_duty <= wr_val[9:0];
    end else if (wb_wr && adr_word == REG_DUTY1) begin
      second_pwm_duty <= wr_val[9:0];
    end
  end

  // refused writes are flagged; a new refusal beats the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reject_flag <= 1'b0;
    end else if (wb_wr && is_func && !code_ok) begin
      reject_flag <= 1'b1;  // see RL20
    end else if (wb_wr && adr_word == REG_STATUS &&
                 wb_sel_i[0] && wb_dat_i[STAT_REJ_BIT]) begin
      reject_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pad input synchroniser
  // ---------------------------------------------------------------
  // pins are asynchronous; only pad_sync is read by logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_meta <= 20'hFFFFF;
      pad_sync <= 20'hFFFFF;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // ---------------------------------------------------------------
  // command mode entry
  // ---------------------------------------------------------------
  // strap: wait for the synchroniser to fill before sampling the line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // break timer runs only while the input line is low and enabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_cnt <= 30'h0;
    end else if (!din_enabled || pad_sync[LINE_SER_IN]) begin
      break_cnt <= 30'h0;
    end else if (break_cnt != 30'(BREAK_CYCLES)) begin
      break_cnt <= break_cnt + 30'h1;  // saturates: one entry per break
    end
  end

  assign break_hit = break_cnt == 30'(BREAK_CYCLES - 1);

  // entry pulse from either path; break counts only in normal mode
  always_comb begin
    enter_cmd = 1'b0;
    if (din_enabled && strap_cnt == STRAP_WAIT - 2'h1 &&
        !pad_sync[LINE_SER_IN]) begin
      enter_cmd = 1'b1;  // see RL11
    end
    if (break_hit && !cmd_mode) begin
      enter_cmd = 1'b1;  // see RL11
    end
  end

  // command mode level; software leaves it by writing one, entry wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_mode <= 1'b0;
    end else if (enter_cmd) begin
      cmd_mode <= 1'b1;
    end else if (wb_wr && adr_word == REG_STATUS &&
                 wb_sel_i[0] && wb_dat_i[STAT_CMD_BIT]) begin
      cmd_mode <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // waveform sources
  // ---------------------------------------------------------------
  // association blink, equal on and off times
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= 25'h0;
      blink_phase <= 1'b0;
    end else if (blink_cnt == 25'(BLINK_CYCLES - 1)) begin
      blink_cnt <= 25'h0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 25'h1;
    end
  end

  // low speed clock; integer divider, so about 32.77 kHz from 125 MHz
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk32_cnt <= 11'h0;
      clk32 <= 1'b0;
    end else if (clk32_cnt == 11'(CLK32_HALF - 1)) begin
      clk32_cnt <= 11'h0;
      clk32 <= ~clk32;  // see RL8
    end else begin
      clk32_cnt <= clk32_cnt + 11'h1;
    end
  end

  // shared 1024 step pwm period counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt <= 10'h0;
    end else begin
      pwm_cnt <= pwm_cnt + 10'h1;  // see RL19
    end
  end

  // first pwm takes rssi or the duty register by its code
  assign first_pwm_out_duty_sel = line_func[LINE_FIRST_PWM_OUT] == CODE_SPECIAL_A ?
                         core_in.rssi_duty : first_pwm_duty;  // see RL6

  // ---------------------------------------------------------------
  // special function drive
  // ---------------------------------------------------------------
  // per line: does a special function own the pin, and at what level
  always_comb begin
    sp_en = 20'h0;
    sp_val = 20'h0;
    // association led lights only in the on phase while joined
    if (line_func[LINE_ASSOC] == CODE_SPECIAL_A) begin
      sp_en[LINE_ASSOC] = 1'b1;  // see RL1
      sp_val[LINE_ASSOC] = core_in.joined & blink_phase;
    end
    // cts is active low: high while the receive buffer is full
    unique case (line_func[LINE_CTS])
      CODE_SPECIAL_A: begin
        sp_en[LINE_CTS] = 1'b1;  // see RL4
        sp_val[LINE_CTS] = core_in.rx_buf_full;
      end
      CODE_SPECIAL_C: begin
        sp_en[LINE_CTS] = 1'b1;  // see RL4
        sp_val[LINE_CTS] = ~core_in.tx_active;
      end
      CODE_SPECIAL_D: begin
        sp_en[LINE_CTS] = 1'b1;  // see RL4
        sp_val[LINE_CTS] = core_in.tx_active;
      end
      default: sp_val[LINE_CTS] = 1'b0;  // digital codes or off
    endcase
    if (line_func[LINE_AWAKE] == CODE_SPECIAL_A) begin
      sp_en[LINE_AWAKE] = 1'b1;
      sp_val[LINE_AWAKE] = core_in.awake;
    end
    if (line_func[LINE_FIRST_PWM_OUT] == CODE_SPECIAL_A ||
        line_func[LINE_FIRST_PWM_OUT] == CODE_SPECIAL_B) begin
      sp_en[LINE_FIRST_PWM_OUT] = 1'b1;  // see RL6
      sp_val[LINE_FIRST_PWM_OUT] = pwm_cnt < first_pwm_out_duty_sel;  // see RL19
    end
    if (line_func[LINE_SECOND_PWM_OUT] == CODE_SPECIAL_A) begin
      sp_en[LINE_SECOND_PWM_OUT] = 1'b1;  // see RL8
      sp_val[LINE_SECOND_PWM_OUT] = clk32;
    end else if (line_func[LINE_SECOND_PWM_OUT] == CODE_SPECIAL_B) begin
      sp_en[LINE_SECOND_PWM_OUT] = 1'b1;  // see RL7
      sp_val[LINE_SECOND_PWM_OUT] = pwm_cnt < second_pwm_duty;  // see RL18
    end
    if (line_func[LINE_12] == CODE_SPECIAL_C) begin
      sp_en[LINE_12] = 1'b1;  // see RL9
      sp_val[LINE_12] = core_in.rx_activity;
    end
    if (line_func[LINE_SER_OUT] == CODE_SPECIAL_A) begin
      sp_en[LINE_SER_OUT] = 1'b1;  // see RL10
      sp_val[LINE_SER_OUT] = core_in.uart_txd;
    end
    if (line_func[LINE_SPI_ATTENTION_OUT] == CODE_SPECIAL_A) begin
      sp_en[LINE_SPI_ATTENTION_OUT] = 1'b1;  // see RL13
      sp_val[LINE_SPI_ATTENTION_OUT] = core_in.spi_attention;
    end else if (line_func[LINE_SPI_ATTENTION_OUT] == CODE_SPECIAL_C) begin
      sp_en[LINE_SPI_ATTENTION_OUT] = 1'b1;  // see RL13
      sp_val[LINE_SPI_ATTENTION_OUT] = core_in.uart_data_present;
    end
  end

  // ---------------------------------------------------------------
  // per line pad control and pull mapping
  // ---------------------------------------------------------------
  for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
    // no legal code is both special and plain digital
    assign passive[l] = line_func[l] == CODE_DISABLED ||
                        line_func[l] == CODE_INPUT;  // see RL16
    assign next_oe_n[l] = ~(sp_en[l] ||
                            line_func[l] == CODE_OUT_LOW ||
                            line_func[l] == CODE_OUT_HIGH);  // see RL2
    assign next_out[l] = sp_en[l] ? sp_val[l] :
                         line_func[l] == CODE_OUT_HIGH;  // see RL2
  end

  // mask bit b serves the line its table entry names
  for (genvar b = 0; b < NUM_LINES; b++) begin : g_pull
    assign next_pull_en[PULL_LINE[b]] =
      pull_enable_mask[b] & passive[PULL_LINE[b]];  // see RL15 see RL17
    assign next_pull_up[PULL_LINE[b]] =
      pull_direction_mask[b];  // see RL14
  end

  // registered pad controls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad.out <= 20'h0;
      pad.oe_n <= 20'hFFFFF;
      pad.pull_en <= 20'h0;
      pad.pull_up <= 20'h0;
    end else begin
      pad.out <= next_out;
      pad.oe_n <= next_oe_n;
      pad.pull_en <= next_pull_en;
      pad.pull_up <= next_pull_up;
    end
  end

  // ---------------------------------------------------------------
  // core side outputs
  // ---------------------------------------------------------------
  // rts is active low; with flow control off the host always may send
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_out <= '0;
    end else begin
      core_out.rts_host_ready <= line_func[LINE_RTS] != CODE_SPECIAL_A ||
                                 !pad_sync[LINE_RTS];  // see RL3
      core_out.sleep_request <= pad_sync[LINE_SLEEP_REQ];  // see RL5
      core_out.uart_rxd <= !din_enabled || pad_sync[LINE_SER_IN];
      core_out.cmd_mode <= cmd_mode;  // see RL11
      core_out.ok_send <= enter_cmd;  // see RL12
    end
  end

endmodule : mpfs_pin_select

`default_nettype wire

//--- testbench/mpfs_pin_select_monitor.sv
/*
  Port checker for the pin select block.
  Assumes the bench binds it to every mpfs_pin_select instance.
*/
`timescale 1ns/1ns
`default_nettype none
module mpfs_pin_select_monitor (
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // core and pads
  input wire mpfs_pkg::mpfs_core_in_t core_in,
  input wire mpfs_pkg::mpfs_core_out_t core_out,
  input wire logic [19:0] pad_in,
  input wire mpfs_pkg::mpfs_pad_t pad
);
  import mpfs_pkg::*;
  // ------
  // helpers
  // ------
  logic [2:0] up_cnt;
  logic [19:0] dir_map;
  // edges since reset; the pad sync needs two before it means anything
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  // write data bits placed on their line numbers
  always_comb begin
    dir_map = '0;
    for (int b = 0; b < 20; b++) dir_map[PULL_LINE[b]] = wb_dat_i[b];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_pull_passive: assert property (
    (pad.pull_en & ~pad.oe_n) == 20'h0) else $error("pull on a driven line");
  a_ok_in_cmd: assert property (core_out.ok_send
    |=> core_out.cmd_mode && !core_out.ok_send) else $error("bad ok pulse");
  a_sleep_follow: assert property (up_cnt == 3'h7 |->
    core_out.sleep_request == $past(pad_in[LINE_SLEEP_REQ], 3))
    else $error("sleep request not passed");
  a_cmd_from_low: assert property ($rose(core_out.cmd_mode)
    |-> !$past(pad_in[LINE_SER_IN], 4)) else $error("command mode unasked");
  a_dir_map: assert property (wb_ack_o && wb_we_i &&
    wb_adr_i == REG_PULL_DIR && wb_sel_i[2:0] == 3'h7
    |=> pad.pull_up == $past(dir_map)) else $error("pull direction map");
endmodule : mpfs_pin_select_monitor
`default_nettype wire

//--- testbench/mpfs_host_model.sv
/*
  Host side: a classic Wishbone master issuing single cycles.
  Assumes its tasks are called just after a rising ref_clk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module mpfs_host_model (
  // clock and answer
  input wire logic ref_clk,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // request
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
  end
  // hold until ack is sampled, then release and leave one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~d; // released data is not left looking valid
    @(posedge ref_clk);
  endtask : xfer
endmodule : mpfs_host_model
`default_nettype wire

//--- testbench/mpfs_pin_select_bench.sv
/*
  Self-checking bench for the pin select block.
  Assumes the design package and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
  mismatches++; $display("FAIL %s exp %0h got %0h", nm, e, s); end end
module mpfs_pin_select_bench;
  import mpfs_pkg::*;
  localparam int BRK = 40;
  localparam int MAP [20] = '{4, 3, 2, 1, 0, 6, 8, 14, 5, 9, 12, 10, 11, 7,
                              13, 15, 16, 17, 18, 19};
  localparam int SPL [8] = '{7, 7, 7, 9, 12, 13, 19, 19};
  localparam int SPC [8] = '{1, 6, 7, 1, 6, 1, 1, 6};
  localparam int SRC [8] = '{16, 15, 15, 14, 13, 12, 11, 10};  // core_in bit
  logic ref_clk, rst_n, cyc, stb, we, ack, e;
  logic [7:0] adr;
  logic [31:0] dat, dat_o, q, hi, t;
  logic [19:0] pad_in, pr, pd;
  logic [9:0] d;
  logic [2:0] c;
  logic [2:0] code [20];
  mpfs_core_in_t core_in;
  mpfs_core_out_t core_out;
  mpfs_pad_t pad;
  int mismatches, num_checks, seed, n;
  mpfs_host_model host (.ref_clk(ref_clk), .wb_ack_o(ack), .wb_dat_o(dat_o),
    .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(dat));
  mpfs_pin_select #(.BREAK_CYCLES(BRK), .BLINK_CYCLES(8)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .core_in(core_in),
    .core_out(core_out), .pad_in(pad_in), .pad(pad));
  // codes each line accepts
  function automatic logic legal(int n, logic [2:0] c);
    case (n)
      5, 6, 9: return c inside {0, 1, [3:5]};
      7: return c != 3'h2;
      10, 11: return c <= 3'h5;
      12: return c inside {0, [3:6]};
      13, 14: return c <= 3'h1;
      19: return c inside {1, 2, [4:6]};
      default: return c inside {0, [3:5]};
    endcase
  endfunction : legal
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // a hang counts as a mismatch; 50k cycles, the tests need about 13k
  initial begin
    #400_000;
    mismatches++;
    conclude();
  end
  initial begin
    seed = 32'he2b45c56;
    rst_n = 1'b0;
    core_in = '0;
    pad_in = 20'hFBFFF; // serial input held low across release
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pad_in <= 20'hFFFFF;
    repeat (3) @(posedge ref_clk);
    rd(REG_STATUS); `CHK("strap", 32'h1, q)
    wr(REG_STATUS, 32'h3);
    for (int k = 0; k < 20; k++) begin
      rd(REG_FUNC_BASE + 8'(4 * k));
      code[k] = q[2:0];
      `CHK("reset code", {29'h0, LINE_RESET[k]}, q)
    end
    rd(REG_PULL_EN); `CHK("pr reset", 32'hFFFFF, q)
    rd(REG_PULL_DIR); `CHK("pd reset", 32'hFFFFF, q)
    rd(REG_DUTY1); `CHK("duty reset", 32'h0, q)
    rd(8'h70); `CHK("unmapped", 32'h0, q)
    // random codes, legal and not
    repeat (40) begin
      n = $unsigned($random(seed)) % 20;
      c = $random(seed);
      wr(REG_FUNC_BASE + 8'(4 * n), {29'h0, c});
      if (legal(n, c)) code[n] = c;
      rd(REG_FUNC_BASE + 8'(4 * n));
      `CHK("code", {29'h0, code[n]}, q)
      rd(REG_STATUS);
      `CHK("reject", {30'h0, !legal(n, c), 1'b0}, q)
      wr(REG_STATUS, 32'h3);
      if (code[n] inside {0, [3:5]}) begin
        `CHK("oe_n", code[n] < 3'h4, pad.oe_n[n])
        if (code[n] > 3'h3) `CHK("out", code[n][0], pad.out[n])
      end
    end
    repeat (3) begin
      pr = $random(seed);
      pd = $random(seed);
      wr(REG_PULL_EN, {12'h0, pr});
      wr(REG_PULL_DIR, {12'h0, pd});
      for (int b = 0; b < 20; b++) begin
        e = pr[b] && (code[MAP[b]] inside {0, 3});
        `CHK("pull en", e, pad.pull_en[MAP[b]])
        `CHK("pull up", pd[b], pad.pull_up[MAP[b]])
      end
    end
    // duty boundaries, counted over one full period
    wr(REG_FUNC_BASE + 8'h28, 32'h2);
    for (int k = 0; k < 4; k++) begin
      d = k == 3 ? 10'($random(seed)) : k == 2 ? 10'h3FF : 10'(k);
      wr(REG_DUTY0, {22'h0, d});
      hi = 32'h0;
      repeat (1024) begin
        @(posedge ref_clk);
        hi = hi + pad.out[LINE_FIRST_PWM_OUT];
      end
      `CHK("pwm high", {22'h0, d}, hi)
    end
    // two full clock periods: half high, four edges
    wr(REG_FUNC_BASE + 8'h2C, 32'h1);
    hi = 32'h0;
    t = 32'h0;
    repeat (4 * CLK32_HALF) begin
      e = pad.out[LINE_SECOND_PWM_OUT];
      @(posedge ref_clk);
      hi = hi + pad.out[LINE_SECOND_PWM_OUT];
      t = t + (pad.out[LINE_SECOND_PWM_OUT] !== e);
    end
    `CHK("clk high", 32'(2 * CLK32_HALF), hi)
    `CHK("clk edges", 32'h4, t)
    for (int k = 0; k < 8; k++) begin
      wr(REG_FUNC_BASE + 8'(4 * SPL[k]), SPC[k]);
      repeat (6) begin
        core_in <= $random(seed);
        pad_in <= $random(seed) | 20'h04000;
        repeat (2) @(posedge ref_clk);
        e = core_in[SRC[k]] ^ (k == 1);  // cts code 6 drives low on transmit
        `CHK("special", e, pad.out[SPL[k]])
      end
    end
    // a short break is ignored, a full one enters command mode
    wr(REG_FUNC_BASE + 8'h38, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(REG_STATUS, 32'h3);
      pad_in[LINE_SER_IN] <= 1'b0;
      repeat (BRK / 2 + k * BRK) @(posedge ref_clk);
      pad_in[LINE_SER_IN] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(REG_STATUS); `CHK("break", k, q)
    end
    conclude();
  end
endmodule : mpfs_pin_select_bench
bind mpfs_pin_select mpfs_pin_select_monitor u_mon (.ref_clk(ref_clk),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .core_in(core_in), .core_out(core_out), .pad_in(pad_in), .pad(pad));
`undef CHK
`default_nettype wire
